/* obpw_regs.svh */
// Register offsets, field positions, reset values and timing counts of the one-bit port.
`ifndef OBPW_REGS_SVH
`define OBPW_REGS_SVH

// -----------------------------------------------------------------------------
// Register offsets (low 16 bits of the address)
// -----------------------------------------------------------------------------
`define OBPW_DIR_OFFSET     16'hffc9
`define OBPW_DATA_OFFSET    16'hffcb

// -----------------------------------------------------------------------------
// Reset values and read constants
// -----------------------------------------------------------------------------
`define OBPW_DIR_RESET      8'h80
`define OBPW_DATA_RESET     8'h80
`define OBPW_DIR_READ       8'hff
`define OBPW_UNMAPPED_READ  8'h00
`define OBPW_UNDEF_READ     1'h1

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define OBPW_PIN_BIT        0
`define OBPW_FIXED_BIT      7

// -----------------------------------------------------------------------------
// Timing counts in MCLK cycles
// -----------------------------------------------------------------------------
`define OBPW_SYNC_STAGES    2
`define OBPW_READ_LATENCY   1

`endif

/* obpw_pkg.sv */
// Types shared by the one-bit port with wait input.
package obpw_pkg;

    // -------------------------------------------------------------------------
    // Data types
    // -------------------------------------------------------------------------
    typedef logic [7:0] obpw_byte_t;

    // Function that the shared pin serves at any moment.
    typedef enum logic [1:0] {
        OBPW_FN_INPUT,
        OBPW_FN_OUTPUT,
        OBPW_FN_WAIT
    } obpw_pin_fn_t;

endpackage

/* obpw_port.sv */
// One-bit general-purpose port whose pin doubles as the external wait-request input.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "obpw_regs.svh"


module obpw_port
    import obpw_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    output logic      [7:0]  RDATA,
    input  wire logic        HW_STANDBY_N,
    input  wire logic        SW_STANDBY,
    input  wire logic [7:0]  AREA_STALL_ENABLE,
    input  wire logic        STALL_MODE_HIGH,
    input  wire logic        STALL_CTRL_OFF,
    input  wire logic        EXT_SAMPLE_STATE,
    output logic             STALL_REQ,
    input  wire logic        PIN_IN,
    output logic             PIN_OUT,
    output logic             PIN_OE
);

    // -------------------------------------------------------------------------
    // Internal signals
    // -------------------------------------------------------------------------
    logic         pin_meta_q;
    logic         pin_sync_q;
    logic         hws_meta_q;
    logic         hws_sync_q;
    logic         init_now;
    obpw_byte_t   dir_q;
    obpw_byte_t   data_q;
    obpw_byte_t   data_d;
    obpw_byte_t   rdata_q;
    obpw_byte_t   data_view;
    logic         out_q;
    logic         stall_req_q;
    logic         port_mode;
    obpw_pin_fn_t pin_fn;
    logic         wr_dir;
    logic         wr_data;
    logic         rd_dir;
    logic         rd_data;

    // Initial data value as a byte, so that single bits of it can be picked out.
    localparam obpw_byte_t data_init = `OBPW_DATA_RESET;

    // -------------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------------

    // The pin level passes two flip-flops before any logic looks at it.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            pin_meta_q <= 1'h1;
            pin_sync_q <= 1'h1;
        end
        else
        begin
            pin_meta_q <= PIN_IN;
            pin_sync_q <= pin_meta_q;
        end
    end

    // The hardware standby pin is synchronised the same way; idle level is high.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            hws_meta_q <= 1'h1;
            hws_sync_q <= 1'h1;
        end
        else
        begin
            hws_meta_q <= HW_STANDBY_N;
            hws_sync_q <= hws_meta_q;
        end
    end

    // Chip reset and hardware standby both put the registers back to their initial values.
    assign init_now = !RESET_N || !hws_sync_q;

    // -------------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------------

    // Writes are dropped in software standby so that the stored state is kept.
    assign wr_dir  = WR_STB && !SW_STANDBY && (ADDR == `OBPW_DIR_OFFSET);
    assign wr_data = WR_STB && !SW_STANDBY && (ADDR == `OBPW_DATA_OFFSET);
    assign rd_dir  = RD_STB && (ADDR == `OBPW_DIR_OFFSET);
    assign rd_data = RD_STB && (ADDR == `OBPW_DATA_OFFSET);

    // -------------------------------------------------------------------------
    // Direction register
    // -------------------------------------------------------------------------

    // Reserved bits are stored too, because they steer the read view of the data bits.
    always_ff @(posedge MCLK)
    begin
        if (init_now)
        begin
            dir_q <= `OBPW_DIR_RESET;
        end
        else if (wr_dir)
        begin
            dir_q <= WDATA;
        end
    end

    // -------------------------------------------------------------------------
    // Data register
    // -------------------------------------------------------------------------

    // Next data value; the top bit is fixed at one whatever is written.
    always_comb
    begin
        data_d = data_q;
        if (wr_data)
        begin
            data_d                 = WDATA;
            data_d[`OBPW_FIXED_BIT] = 1'h1;
        end
    end

    // Storage for the pin bit and the unconnected bits.
    always_ff @(posedge MCLK)
    begin
        if (init_now)
        begin
            data_q <= `OBPW_DATA_RESET;
        end
        else
        begin
            data_q <= data_d;
        end
    end

    // -------------------------------------------------------------------------
    // Pin function selection
    // -------------------------------------------------------------------------

    // The pin is an ordinary port only while every area enable is set and mode-high is clear.
    assign port_mode = (&AREA_STALL_ENABLE) && !STALL_MODE_HIGH;

    // Function the pin serves now, as seen by the output and wait logic.
    always_comb
    begin
        if (!port_mode)
        begin
            pin_fn = OBPW_FN_WAIT;
        end
        else if (dir_q[`OBPW_PIN_BIT])
        begin
            pin_fn = OBPW_FN_OUTPUT;
        end
        else
        begin
            pin_fn = OBPW_FN_INPUT;
        end
    end

    // -------------------------------------------------------------------------
    // Pin driver
    // -------------------------------------------------------------------------

    // The output level follows the data bit, and freezes while software standby lasts.
    always_ff @(posedge MCLK)
    begin
        if (init_now)
        begin
            out_q <= data_init[`OBPW_PIN_BIT];
        end
        else if (!SW_STANDBY)
        begin
            out_q <= data_d[`OBPW_PIN_BIT];
        end
    end

    // The driver is enabled only in port mode with the direction bit set.
    assign PIN_OUT = out_q;
    assign PIN_OE  = (pin_fn == OBPW_FN_OUTPUT);

    // -------------------------------------------------------------------------
    // Wait request
    // -------------------------------------------------------------------------

    // A low pin in the sample state of an external three-state access asks for a wait.
    always_ff @(posedge MCLK)
    begin
        if (init_now)
        begin
            stall_req_q <= 1'h0;
        end
        else
        begin
            stall_req_q <= (pin_fn == OBPW_FN_WAIT) && STALL_CTRL_OFF
                           && EXT_SAMPLE_STATE && !pin_sync_q;
        end
    end

    assign STALL_REQ = stall_req_q;

    // -------------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------------

    // Read view of the data register, built one bit at a time.
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_view
            if (i == `OBPW_FIXED_BIT)
            begin : g_fixed
                assign data_view[i] = 1'h1;
            end
            else if (i == `OBPW_PIN_BIT)
            begin : g_pin
                assign data_view[i] = dir_q[i] ? data_q[i] : pin_sync_q;
            end
            else if (i >= 3 && i <= 5)
            begin : g_undef
                assign data_view[i] = dir_q[i] ? data_q[i] : `OBPW_UNDEF_READ;
            end
            else
            begin : g_plain
                assign data_view[i] = dir_q[i] ? data_q[i] : 1'h1;
            end
        end
    endgenerate

    // Read data stand in the cycle after the strobe only; other cycles show zero.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            rdata_q <= 8'h00;
        end
        else if (rd_dir)
        begin
            rdata_q <= `OBPW_DIR_READ;
        end
        else if (rd_data)
        begin
            rdata_q <= data_view;
        end
        else
        begin
            rdata_q <= `OBPW_UNMAPPED_READ;
        end
    end

    assign RDATA = rdata_q;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------

    default clocking cb @(posedge MCLK);
    endclocking

    default disable iff (!RESET_N);

    // Direction reads always return all ones.
    chk_dir_read_ones: assert property (
        rd_dir |=> (RDATA == 8'hff))
        else $error("direction register read did not return all ones");

    // A write of one to the direction bit in port mode enables the driver next cycle.
    chk_dir_drives_pin: assert property (
        (wr_dir && WDATA[0] && !init_now && port_mode ##1 port_mode) |-> PIN_OE)
        else $error("pin not driven after direction set in port mode");

    // Hardware standby brings both registers to their initial values.
    chk_standby_init: assert property (
        !hws_sync_q |=> (dir_q == 8'h80) && (data_q == 8'h80))
        else $error("registers not initialised in hardware standby");

    // Software standby keeps the direction register unchanged.
    chk_sw_keeps_dir: assert property (
        (SW_STANDBY && hws_sync_q) |=> $stable(dir_q) && $stable(data_q))
        else $error("register changed during software standby");

    // The output level stays put for as long as software standby lasts.
    chk_standby_hold: assert property (
        (SW_STANDBY && hws_sync_q) ##1 SW_STANDBY |-> $stable(PIN_OUT))
        else $error("pin output moved during software standby");

    // An output bit reads back its stored value.
    chk_read_stored: assert property (
        (rd_data && dir_q[0]) |=> (RDATA[0] == $past(data_q[0])))
        else $error("output pin read did not return stored bit");

    // An input bit reads back the synchronised pin level.
    chk_read_pin: assert property (
        (rd_data && !dir_q[0]) |=> (RDATA[0] == $past(pin_sync_q)))
        else $error("input pin read did not return pin level");

    // The top data bit survives a write of zero and stays stored as one.
    chk_fixed_bit: assert property (
        (wr_data && !WDATA[7]) |=> data_q[7] ##1 1'h1)
        else $error("data bit 7 took a written zero");

    // Plain bits read one when their direction bit is clear.
    chk_plain_bits: assert property (
        (rd_data && !dir_q[6] && !dir_q[2] && !dir_q[1])
        |=> RDATA[6] && RDATA[2] && RDATA[1])
        else $error("plain bit with clear direction did not read one");

    // Middle bit 4 reads its stored value when its direction bit is set.
    chk_mid_bits: assert property (
        (rd_data && dir_q[4]) |=> (RDATA[4] == $past(data_q[4])))
        else $error("middle bit did not read its stored value");

    // Leaving port mode releases the pin at once.
    chk_wait_no_drive: assert property (
        !port_mode |-> !PIN_OE)
        else $error("pin driven while serving as wait input");

    // A low pin in the sample state raises the wait request one cycle later.
    chk_wait_request: assert property (
        ((pin_fn == OBPW_FN_WAIT) && STALL_CTRL_OFF && EXT_SAMPLE_STATE
         && !pin_sync_q && !init_now) |=> STALL_REQ)
        else $error("wait request missing for low pin in sample state");

    // A stall request never appears in the cycle after one in which the pin acts as a port.
    chk_no_port_wait: assert property (
        $past(port_mode) |-> !STALL_REQ)
        else $error("wait request raised while pin is a port");

    // Main scenarios reached.
    cov_output_drive: cover property (wr_dir && WDATA[0] ##1 PIN_OE);
    cov_input_read:   cover property (rd_data && !dir_q[0] && !pin_sync_q);
    cov_wait_insert:  cover property (STALL_REQ [*2]);
    cov_sw_standby:   cover property (PIN_OE && SW_STANDBY [*3]);

endmodule

`default_nettype wire

/* obpw_ext_dev.sv */
// Behavioural model of the external device that requests wait states on the shared pin.
`timescale 1ns/1ps
`default_nettype none
module obpw_ext_dev
(
    input  wire logic clk,
    input  wire logic drive_en,
    input  wire logic level,
    output logic      dev_oe,
    output logic      dev_out
);
    // The device changes its drive just after a rising edge and holds it for whole cycles.
    always_ff @(posedge clk)
    begin
        dev_oe  <= drive_en;
        dev_out <= level;
    end
endmodule
`default_nettype wire

/* obpw_port_test.sv */
// Self-checking testbench of the one-bit port with wait input.
`timescale 1ns/1ps
`default_nettype none
`include "obpw_regs.svh"
module obpw_port_test;
    import obpw_pkg::*;
    logic        mclk = 1'h0, reset_n = 1'h0, wr_stb = 1'h0, rd_stb = 1'h0;
    logic        hw_sb_n = 1'h1, sw_sb = 1'h0, mh = 1'h0, ctrl_off = 1'h0, samp = 1'h0;
    logic        stall, pin_out, pin_oe, dev_oe, dev_out, drv = 1'h1, lvl = 1'h1, last_q = 1'h1;
    logic [15:0] addr = 16'h0000;
    obpw_byte_t  wdata = 8'h00, ae = 8'hff, rdata;
    wire logic   pin_lvl;
    int          fails = 0, total_checks = 0;

    // Free-running system clock of 20 ns period.
    always #10 mclk = ~mclk;

    // A released line with no driver shows the inverse of its last level.
    always @(posedge mclk) last_q <= pin_lvl;
    assign pin_lvl = pin_oe ? pin_out : (dev_oe ? dev_out : ~last_q);

    obpw_port dut (.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .HW_STANDBY_N(hw_sb_n),
        .SW_STANDBY(sw_sb), .AREA_STALL_ENABLE(ae), .STALL_MODE_HIGH(mh),
        .STALL_CTRL_OFF(ctrl_off), .EXT_SAMPLE_STATE(samp), .STALL_REQ(stall),
        .PIN_IN(pin_lvl), .PIN_OUT(pin_out), .PIN_OE(pin_oe));

    obpw_ext_dev ext (.clk(mclk), .drive_en(drv), .level(lvl), .dev_oe(dev_oe),
        .dev_out(dev_out));

    // Closing report, also reached when a bounded wait runs out.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Byte and bit comparisons.
    task automatic chk8(input obpw_byte_t got, input obpw_byte_t exp);
        total_checks++;
        if (got !== exp)
            $display("MISMATCH at %0t: byte %h expected %h", $time, got, exp);
        if (got !== exp)
            fails++;
    endtask

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
            $display("MISMATCH at %0t: bit %b expected %b", $time, got, exp);
        if (got !== exp)
            fails++;
    endtask

    // One-cycle write; returns just after the edge that takes it.
    task automatic wr(input logic [15:0] a, input obpw_byte_t d);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'h1;
        @(posedge mclk);
        wr_stb <= 1'h0;
        #1;
    endtask

    // One-cycle read; data is compared in the cycle after the strobe.
    task automatic rdchk(input logic [15:0] a, input obpw_byte_t exp);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'h1;
        @(posedge mclk);
        rd_stb <= 1'h0;
        #1;
        chk8(rdata, exp);
    endtask

    // Bounded wait for the wait request to reach a level.
    task automatic wait_stall(input logic v);
        int n;
        n = 0;
        while (stall !== v && n < 10)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk1(stall, v);
        if (stall !== v)
            tally_and_finish();
    endtask

    // Reset values, write-only direction and unmapped address.
    task automatic t_reset;
        @(posedge mclk);
        lvl <= 1'h0;
        repeat (4) @(posedge mclk);
        chk1(pin_oe, 1'h0);
        rdchk(`OBPW_DIR_OFFSET, 8'hff);
        rdchk(`OBPW_DATA_OFFSET, 8'hfe);
        rdchk(16'hffca, 8'h00);
        drv <= 1'h0;
        wr(`OBPW_DIR_OFFSET, 8'hff);
        rdchk(`OBPW_DATA_OFFSET, 8'h80);
    endtask

    // Read view of stored bits and of the pin for both directions.
    task automatic t_data;
        @(posedge mclk);
        drv <= 1'h0;
        wr(`OBPW_DATA_OFFSET, 8'h55);
        chk1(pin_oe, 1'h1);
        chk1(pin_out, 1'h1);
        rdchk(`OBPW_DATA_OFFSET, 8'hd5);
        wr(`OBPW_DIR_OFFSET, 8'h7e);
        drv <= 1'h1;
        rdchk(`OBPW_DIR_OFFSET, 8'hff);
        repeat (4) @(posedge mclk);
        chk1(pin_oe, 1'h0);
        rdchk(`OBPW_DATA_OFFSET, 8'hd4);
        wr(`OBPW_DIR_OFFSET, 8'h00);
        rdchk(`OBPW_DATA_OFFSET, 8'hfe);
        lvl <= 1'h1;
        repeat (4) @(posedge mclk);
        rdchk(`OBPW_DATA_OFFSET, 8'hff);
    endtask

    // Software standby keeps the registers and the driven level.
    task automatic t_sw;
        @(posedge mclk);
        drv <= 1'h0;
        wr(`OBPW_DIR_OFFSET, 8'h01);
        wr(`OBPW_DATA_OFFSET, 8'h01);
        @(posedge mclk);
        sw_sb <= 1'h1;
        wr(`OBPW_DATA_OFFSET, 8'h00);
        wr(`OBPW_DIR_OFFSET, 8'h00);
        repeat (3) @(posedge mclk);
        chk1(pin_oe, 1'h1);
        chk1(pin_out, 1'h1);
        sw_sb <= 1'h0;
        rdchk(`OBPW_DATA_OFFSET, 8'hff);
    endtask

    // Pin as wait input with mode-high set, and with area enable bit 0 or bit 7 clear.
    task automatic t_wait;
        obpw_byte_t ae_tab [3] = '{8'hff, 8'hfe, 8'h7f};
        logic       mh_tab [3] = '{1'h1, 1'h0, 1'h0};
        wr(`OBPW_DIR_OFFSET, 8'h00);
        @(posedge mclk);
        drv      <= 1'h1;
        lvl      <= 1'h0;
        ctrl_off <= 1'h1;
        samp     <= 1'h1;
        repeat (6) @(posedge mclk);
        chk1(stall, 1'h0);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge mclk);
            ae <= ae_tab[i];
            mh <= mh_tab[i];
            wait_stall(1'h1);
            chk1(pin_oe, 1'h0);
            lvl <= 1'h1;
            wait_stall(1'h0);
            lvl <= 1'h0;
        end
        @(posedge mclk);
        samp     <= 1'h0;
        repeat (5) @(posedge mclk);
        chk1(stall, 1'h0);
        samp     <= 1'h1;
        ctrl_off <= 1'h0;
        repeat (6) @(posedge mclk);
        chk1(stall, 1'h0);
        ae <= 8'hff;
        mh <= 1'h0;
    endtask

    // Hardware standby reinitialises both registers.
    task automatic t_hw;
        @(posedge mclk);
        drv <= 1'h0;
        wr(`OBPW_DIR_OFFSET, 8'hff);
        wr(`OBPW_DATA_OFFSET, 8'h01);
        @(posedge mclk);
        hw_sb_n <= 1'h0;
        repeat (5) @(posedge mclk);
        hw_sb_n <= 1'h1;
        repeat (4) @(posedge mclk);
        #1;
        chk1(pin_oe, 1'h0);
        chk1(pin_out, 1'h0);
        wr(`OBPW_DIR_OFFSET, 8'hff);
        rdchk(`OBPW_DATA_OFFSET, 8'h80);
    endtask

    // Main sequence: reset for twelve cycles, then every scenario.
    initial
    begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'h1;
        t_reset();
        t_data();
        t_sw();
        t_wait();
        t_hw();
        tally_and_finish();
    end
endmodule
`default_nettype wire
